// File: src/tws_pkg.sv
/*
  Constants, encodings and carrier types for the three-wire serial
  EEPROM command block. Assumes a 100 MHz ref_clk.
*/
package tws_pkg;

  localparam int CLK_PERIOD_NS = 10;
  // Longest self-timed write, rounded down to whole clocks
  localparam int WRITE_CYCLE_TIME_NS = 5000000;
  localparam int WRITE_CYCLE_CLKS = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 20;

  localparam int MEM_BYTES = 256;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;

  localparam logic [4:0] ADDR_LEN_X8 = 5'h09;
  localparam logic [4:0] ADDR_LEN_X16 = 5'h08;
  localparam logic [4:0] DATA_LEN_X8 = 5'h08;
  localparam logic [4:0] DATA_LEN_X16 = 5'h10;
  localparam logic [4:0] OPC_BITS_LEFT = 5'h01;

  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] OPC_MISC = 2'h0;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0] SUB_DISABLE = 2'h0;

  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [8:0] ALL_BYTES = 9'h100;
  localparam logic [8:0] ONE_BYTE = 9'h001;
  localparam logic [8:0] TWO_BYTES = 9'h002;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_READ = 6'h10,
    ST_WAIT = 6'h20
  } tws_state_t;

  // One programming job: fill count bytes from start with a pattern
  typedef struct packed {
    logic [7:0] start;
    logic [8:0] count;
    logic [15:0] data;
  } tws_prog_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic sk_s1;
    logic sk_s2;
    logic sk_prev;
    logic di_s1;
    logic di_s2;
    logic org_s1;
    logic org_s2;
    tws_state_t st;
    logic [4:0] cnt;
    logic [1:0] opc;
    logic [8:0] sr;
    logic [7:0] adr;
    logic [15:0] dat;
    logic wide;
    logic en;
    logic show;
    logic [15:0] sh;
    logic [4:0] ocnt;
    logic dout;
    logic oe;
    logic busy;
    logic [TMR_W-1:0] tmr;
    logic [7:0] pa;
    logic [8:0] pn;
    logic [15:0] pdat;
    logic pwide;
    logic rd_on;
    logic [7:0] ra;
  } tws_regs_t;

endpackage

// File: src/tws_eeprom.sv
/*
  Serial command decoder, read streamer, self-timed programmer and the
  read-ahead FIFO of a 2-kbit three-wire serial EEPROM.
  Assumes all four pins are asynchronous to ref_clk and that the shift
  clock runs well below ref_clk/4 so every edge is seen.
*/
`timescale 1ns/1ps

module tws_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } tws_fifo_state_t;

  tws_fifo_state_t s_reg;
  tws_fifo_state_t s_next;
  logic [WIDTH-1:0] buf_mem [0:DEPTH-1];
  logic push;
  logic pop;

  assign in_ready = (s_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data = buf_mem[s_reg.rp];
  assign push = in_valid & in_ready & ~flush;
  assign pop = out_valid & out_ready & ~flush;

  always_comb
  begin
    s_next = s_reg;
    if (flush)
    begin
      s_next = '0;
    end
    else
    begin
      if (push)
      begin
        s_next.wp = s_reg.wp + 1'b1;
      end
      if (pop)
      begin
        s_next.rp = s_reg.rp + 1'b1;
      end
      s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      buf_mem[s_reg.wp] <= in_data;
    end
  end
endmodule // tws_fifo

// Summary of operation
// - Strap high gives 16-bit words, low 8-bit.
// - Instruction is start bit, opcode, address.
// - Opcode 10 reads addressed word.
// - Opcode 00 with 11 enables programming.
// - Opcode 11 erases one addressed word.
// - Opcode 01 writes data word at address.
// - Opcode 00 with 10 erases everything.
// - Opcode 00 with 01 writes word everywhere.
// - Opcode 00 with 00 disables programming.
// - Read data changes on shift-clock rising edges.
// - Dummy zero, then word, MSB first.
// - Held select streams next words, no dummy.
// - Power-up leaves programming disabled.
// - Enable persists until disable or power loss.
// - Writes self-timed, bounded by write cycle time.
// - Select raised after write shows ready/busy.
// - Programming only starts while enabled.
module tws_eeprom
  import tws_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLE_CLKS
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic word_width_select,
  output logic serial_out,
  output logic serial_out_oe,
  output logic write_busy,
  output logic program_enabled
);
  tws_regs_t r_reg;
  tws_regs_t r_next;
  logic [7:0] mem [0:MEM_BYTES-1];
  logic mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;
  logic sk_rise;
  logic fifo_flush;
  logic fifo_push;
  logic fifo_in_ready;
  logic [15:0] fifo_wdata;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [15:0] fifo_rdata;

  function automatic logic [4:0] addr_len(input logic wide);
    return wide ? ADDR_LEN_X16 : ADDR_LEN_X8;
  endfunction

  function automatic logic [4:0] data_len(input logic wide);
    return wide ? DATA_LEN_X16 : DATA_LEN_X8;
  endfunction

  // x16 word w sits in bytes 2w (high) and 2w+1 (low)
  function automatic logic [7:0] byte_addr(input logic [8:0] a,
                                           input logic wide);
    return wide ? {a[6:0], 1'b0} : a[7:0];
  endfunction

  assign sk_rise = r_reg.sk_s2 & ~r_reg.sk_prev;
  assign serial_out = r_reg.dout;
  assign serial_out_oe = r_reg.oe;
  assign write_busy = r_reg.busy;
  assign program_enabled = r_reg.en;

  tws_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .flush(fifo_flush),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_wdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_rdata)
  );

  always_comb
  begin
    logic [8:0] a;
    logic [15:0] d;
    logic [15:0] w;
    logic [1:0] sub;
    logic go;
    tws_prog_t job;
    a = '0;
    d = '0;
    w = '0;
    sub = '0;
    go = 1'b0;
    job = '0;
    r_next = r_reg;
    mem_we = 1'b0;
    mem_wa = r_reg.pa;
    mem_wd = '0;
    fifo_flush = 1'b0;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    fifo_wdata = '0;

    r_next.cs_s1 = chip_select;
    r_next.cs_s2 = r_reg.cs_s1;
    r_next.sk_s1 = serial_clock;
    r_next.sk_s2 = r_reg.sk_s1;
    r_next.sk_prev = r_reg.sk_s2;
    r_next.di_s1 = serial_in;
    r_next.di_s2 = r_reg.di_s1;
    r_next.org_s1 = word_width_select;
    r_next.org_s2 = r_reg.org_s1;

    // Programmer runs on its own, no shift clock needed
    if (r_reg.busy)
    begin
      if (r_reg.pn != '0)
      begin
        mem_we = 1'b1;
        if (r_reg.pwide && !r_reg.pa[0])
        begin
          mem_wd = r_reg.pdat[15:8];
        end
        else
        begin
          mem_wd = r_reg.pdat[7:0];
        end
        r_next.pa = r_reg.pa + 8'h01;
        r_next.pn = r_reg.pn - 9'h001;
      end
      if (r_reg.tmr != '0)
      begin
        r_next.tmr = r_reg.tmr - 1'b1;
      end
      else if (r_reg.pn == '0)
      begin
        r_next.busy = 1'b0;
      end
    end

    // Read-ahead keeps the FIFO topped up; full FIFO stalls it
    if (r_reg.rd_on)
    begin
      if (r_reg.wide)
      begin
        fifo_wdata = {mem[r_reg.ra], mem[r_reg.ra + 8'h01]};
      end
      else
      begin
        fifo_wdata = {8'h00, mem[r_reg.ra]};
      end
      fifo_push = 1'b1;
      if (fifo_in_ready)
      begin
        r_next.ra = r_reg.ra + (r_reg.wide ? 8'h02 : 8'h01);
      end
    end

    if (!r_reg.cs_s2)
    begin
      // Deselect aborts any instruction and frees the pin
      r_next.st = ST_IDLE;
      r_next.oe = 1'b0;
      r_next.rd_on = 1'b0;
      fifo_flush = 1'b1;
    end
    else
    begin
      if (r_reg.st == ST_IDLE && r_reg.show)
      begin
        r_next.oe = 1'b1;
        r_next.dout = ~r_reg.busy;
      end
      if (sk_rise)
      begin
        unique case (r_reg.st)
          ST_IDLE:
          begin
            // Leading zeros before the start bit are skipped
            if (r_reg.di_s2)
            begin
              r_next.st = ST_OPC;
              r_next.cnt = OPC_BITS_LEFT;
              r_next.wide = r_reg.org_s2;
              r_next.show = 1'b0;
              r_next.oe = 1'b0;
            end
          end
          ST_OPC:
          begin
            r_next.opc = {r_reg.opc[0], r_reg.di_s2};
            if (r_reg.cnt == '0)
            begin
              r_next.st = ST_ADDR;
              r_next.cnt = addr_len(r_reg.wide) - 5'h01;
            end
            else
            begin
              r_next.cnt = r_reg.cnt - 5'h01;
            end
          end
          ST_ADDR:
          begin
            a = {r_reg.sr[7:0], r_reg.di_s2};
            r_next.sr = a;
            // Don't-care bits still count toward the field length
            if (r_reg.cnt != '0)
            begin
              r_next.cnt = r_reg.cnt - 5'h01;
            end
            else
            begin
              sub = r_reg.wide ? a[7:6] : a[8:7];
              r_next.st = ST_WAIT;
              r_next.adr = byte_addr(a, r_reg.wide);
              unique case (r_reg.opc)
                OPC_READ:
                begin
                  // Reads during a write cycle are dropped
                  if (!r_reg.busy)
                  begin
                    r_next.st = ST_READ;
                    r_next.rd_on = 1'b1;
                    r_next.ra = byte_addr(a, r_reg.wide);
                    fifo_flush = 1'b1;
                    r_next.dout = 1'b0;
                    r_next.oe = 1'b1;
                    r_next.ocnt = '0;
                  end
                end
                OPC_ERASE:
                begin
                  go = 1'b1;
                  job.start = byte_addr(a, r_reg.wide);
                  job.count = r_reg.wide ? TWO_BYTES : ONE_BYTE;
                  job.data = ERASED_WORD;
                end
                OPC_WRITE:
                begin
                  r_next.st = ST_DATA;
                  r_next.cnt = data_len(r_reg.wide) - 5'h01;
                end
                OPC_MISC:
                begin
                  unique case (sub)
                    SUB_ENABLE: r_next.en = 1'b1;
                    SUB_DISABLE: r_next.en = 1'b0;
                    SUB_ERASE_ALL:
                    begin
                      go = 1'b1;
                      job.start = '0;
                      job.count = ALL_BYTES;
                      job.data = ERASED_WORD;
                    end
                    SUB_WRITE_ALL:
                    begin
                      r_next.st = ST_DATA;
                      r_next.adr = '0;
                      r_next.cnt = data_len(r_reg.wide) - 5'h01;
                    end
                  endcase
                end
              endcase
            end
          end
          ST_DATA:
          begin
            d = {r_reg.dat[14:0], r_reg.di_s2};
            r_next.dat = d;
            if (r_reg.cnt != '0)
            begin
              r_next.cnt = r_reg.cnt - 5'h01;
            end
            else
            begin
              r_next.st = ST_WAIT;
              go = 1'b1;
              job.start = r_reg.adr;
              job.data = d;
              if (r_reg.opc == OPC_MISC)
              begin
                job.count = ALL_BYTES;
              end
              else
              begin
                job.count = r_reg.wide ? TWO_BYTES : ONE_BYTE;
              end
            end
          end
          ST_READ:
          begin
            if (r_reg.ocnt == '0)
            begin
              // Word boundary: next word follows with no dummy bit
              fifo_pop = 1'b1;
              w = r_reg.wide ? fifo_rdata : {fifo_rdata[7:0], 8'h00};
              r_next.dout = w[15];
              r_next.sh = {w[14:0], 1'b0};
              r_next.ocnt = data_len(r_reg.wide) - 5'h01;
            end
            else
            begin
              r_next.dout = r_reg.sh[15];
              r_next.sh = {r_reg.sh[14:0], 1'b0};
              r_next.ocnt = r_reg.ocnt - 5'h01;
            end
          end
          ST_WAIT:
          begin
            r_next.st = ST_WAIT;
          end
        endcase
      end
    end

    // Discard programming when disabled or a cycle is running
    if (go && r_reg.en && !r_reg.busy)
    begin
      r_next.busy = 1'b1;
      r_next.tmr = TMR_W'(WRITE_CYCLES - 1);
      r_next.pa = job.start;
      r_next.pn = job.count;
      r_next.pdat = job.data;
      r_next.pwide = r_reg.wide;
      r_next.show = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Array is not reset: its contents are nonvolatile
  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
    begin
      mem[mem_wa] <= mem_wd;
    end
  end
endmodule // tws_eeprom

// File: bench/tws_eeprom_assertions.sv
/*
  Pin checker for tws_eeprom.
  Assumes ref_clk domain only; bound onto every tws_eeprom.
*/
`timescale 1ns/1ps
module tws_eeprom_chk #(
  parameter int WRITE_CYCLES = 500000
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic word_width_select,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic write_busy,
  input wire logic program_enabled
);
  logic [31:0] busy_cnt_reg;
  always_ff @(posedge ref_clk)
    busy_cnt_reg <= (sys_rst || !write_busy) ? 32'h0 : busy_cnt_reg + 32'h1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_oe_release: assert property (
    !chip_select [*5] |-> !serial_out_oe) else $error("oe without select");
  chk_oe_select: assert property (
    $rose(serial_out_oe) |-> chip_select) else $error("oe rose unselected");
  chk_out_edge: assert property (
    $changed(serial_out) && serial_out_oe && $past(serial_out_oe)
    && chip_select && !$past(write_busy) && !$past(write_busy, 2)
    |-> $past(serial_clock, 2)) else $error("output off clock rise");
  chk_busy_enabled: assert property (
    $rose(write_busy) |-> program_enabled) else $error("busy while locked");
  chk_busy_start: assert property (
    $rose(write_busy) |-> chip_select && $past(serial_clock, 2))
    else $error("busy not at last bit");
  chk_busy_len: assert property (
    busy_cnt_reg <= WRITE_CYCLES + 1) else $error("busy too long");
  chk_busy_exact: assert property (
    $fell(write_busy) |-> busy_cnt_reg == WRITE_CYCLES)
    else $error("busy length off");
  chk_enable_cmd: assert property (
    $changed(program_enabled) |-> chip_select && $past(serial_clock, 2))
    else $error("enable changed outside command");
  chk_idle_quiet: assert property (
    !chip_select [*5] |-> !$rose(write_busy) && $stable(program_enabled))
    else $error("activity while unselected");
  chk_status_busy: assert property (
    write_busy && serial_out_oe |-> !serial_out) else $error("busy not low");
  chk_status_ready: assert property (
    $fell(write_busy) && chip_select |-> ##[1:6] serial_out_oe && serial_out)
    else $error("ready not shown");
endmodule // tws_eeprom_chk

bind tws_eeprom tws_eeprom_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .chip_select(chip_select),
  .serial_clock(serial_clock), .serial_in(serial_in),
  .word_width_select(word_width_select), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .write_busy(write_busy),
  .program_enabled(program_enabled));

// File: bench/tws_host.sv
/*
  Host side of the three-wire link: select, shift clock, data in.
  Assumes ref_clk at 100 MHz; shift clock 160 ns, low between frames.
*/
`timescale 1ns/1ps
module tws_host (
  input wire logic ref_clk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  output logic chip_select,
  output logic serial_clock,
  output logic serial_in
);
  initial
  begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic select(input logic v);
    wait_clk(8);
    chip_select = v;
    wait_clk(8);
  endtask
  // Released line reads as the inverse of its last bit
  task automatic send(input int n, input logic [31:0] v,
                      output logic [31:0] r);
    r = 32'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = v[i];
      wait_clk(8);
      serial_clock = 1'b1;
      wait_clk(8);
      r = {r[30:0], serial_out_oe ? serial_out : !r[0]};
      serial_clock = 1'b0;
    end
  endtask
endmodule // tws_host

// File: bench/tws_eeprom_tb.sv
/*
  Self-checking bench for tws_eeprom with a byte-array model.
  Assumes tws_host as the far side and the bound pin checker.
*/
`timescale 1ns/1ps
module tws_eeprom_tb;
  import tws_pkg::*;
  localparam int WCYC = 400;
  logic ref_clk, sys_rst, word_width_select, chip_select, serial_clock;
  logic serial_in, serial_out, serial_out_oe, write_busy, program_enabled;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 32'h3a1e3ce7;
  int mem [256];
  int a;
  bit en_m = 1'b0;
  tws_eeprom #(.WRITE_CYCLES(WCYC)) dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in),
    .word_width_select(word_width_select), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .write_busy(write_busy),
    .program_enabled(program_enabled));
  tws_host host (.ref_clk(ref_clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic put(input int a, input int d, input bit w);
    if (w)
    begin
      mem[2 * a] = d >> 8;
      mem[2 * a + 1] = d & 255;
    end
    else
      mem[a] = d & 255;
  endtask
  task automatic prog(input logic [1:0] opc, input int x, input int d);
    logic [31:0] v, r;
    int al, dl, ad, n, k;
    bit w, acc, hd, misc;
    w = word_width_select;
    al = w ? 8 : 9;
    dl = w ? 16 : 8;
    d = d & ((1 << dl) - 1);
    misc = opc == OPC_MISC;
    ad = misc ? (x << (al - 2)) | ($random(seed) & 63) : x;
    hd = opc == OPC_WRITE || (misc && x == SUB_WRITE_ALL);
    acc = en_m && !(misc && x[1] == x[0]);
    v = ({30'h0, opc} | 32'h4) << al | (ad & ((1 << al) - 1));
    n = 3 + al;
    if (hd)
    begin
      v = (v << dl) | d;
      n = n + dl;
    end
    host.select(1'b1);
    host.send(n, v, r);
    check("busy start", acc, write_busy);
    host.select(1'b0);
    if (misc && x == SUB_ENABLE)
      en_m = 1'b1;
    if (misc && x == SUB_DISABLE)
      en_m = 1'b0;
    for (int i = 0; acc && i < (w ? 128 : 256); i++)
      if (misc || i == (ad & (w ? 127 : 255)))
        put(i, (opc == OPC_ERASE || misc && x == 2) ? 'hffff : d, w);
    check("enable", en_m, program_enabled);
    if (acc)
    begin
      host.select(1'b1);
      check("status busy", 1'b0, serial_out);
      check("status oe", 1'b1, serial_out_oe);
      for (k = 0; serial_out !== 1'b1 && k < 700; k++)
        host.wait_clk(1);
      check("ready", 2'b10, {serial_out, write_busy});
      host.select(1'b0);
    end
  endtask
  task automatic rd(input int ad, input int nw);
    logic [31:0] v, r;
    int al, dl, e;
    bit w;
    w = word_width_select;
    al = w ? 8 : 9;
    dl = w ? 16 : 8;
    v = 32'h6 << al | (ad & ((1 << al) - 1));
    ad = ad & (w ? 127 : 255);
    host.select(1'b1);
    host.send(3 + al, v, r);
    check("dummy", 1'b0, r[0]);
    repeat (nw)
    begin
      host.send(dl, $random(seed), r);
      e = w ? mem[2 * ad] << 8 | mem[2 * ad + 1] : mem[ad];
      check("word", e, r);
      ad = (ad + 1) % (w ? 128 : 256);
    end
    host.select(1'b0);
    check("oe off", 1'b0, serial_out_oe);
  endtask
  // Power-up model: programming must come back locked
  task automatic pulse_reset();
    sys_rst = 1'b1;
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    en_m = 1'b0;
    check("enable reset", 1'b0, program_enabled);
  endtask
  initial
  begin
    #800000;
    miscompares++;
    complete_run();
  end
  initial
  begin
    word_width_select = 1'b1;
    pulse_reset();
    prog(OPC_WRITE, 3, $random(seed));
    prog(OPC_MISC, SUB_ENABLE, 0);
    prog(OPC_MISC, SUB_WRITE_ALL, $random(seed));
    rd(126, 4);
    $display("test enable and write all done");
    for (int i = 0; i < 4; i++)
    begin
      word_width_select = i[0];
      a = $random(seed) & 255;
      prog(OPC_WRITE, a, $random(seed));
      rd(a, 2);
    end
    $display("test word writes done");
    prog(OPC_ERASE, a, 0);
    rd(a - 1, 3);
    word_width_select = 1'b0;
    prog(OPC_MISC, SUB_ERASE_ALL, 0);
    rd(250, 8);
    $display("test erase done");
    prog(OPC_MISC, SUB_DISABLE, 0);
    prog(OPC_WRITE, 7, $random(seed));
    rd(7, 1);
    $display("test disable done");
    prog(OPC_MISC, SUB_ENABLE, 0);
    pulse_reset();
    prog(OPC_WRITE, 9, $random(seed));
    rd(9, 1);
    $display("test reset lock done");
    complete_run();
  end
endmodule // tws_eeprom_tb
